// >>> src/ext_bus_pkg.sv
// constants shared by the sdram strobe, direct-transfer and bus-hold logic
package ext_bus_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 20;
  // apb register byte offsets
  localparam logic [7:0] OFF_GLOBAL_CTRL = 8'h00;
  localparam logic [7:0] OFF_XFER_CTRL = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_BOOT = 8'h10;
  // iface_global_ctrl fields
  localparam int unsigned BIT_HOLD_DISABLE = 0;
  localparam int unsigned BIT_FLOAT_SEL1 = 1;
  localparam int unsigned BIT_FLOAT_SEL2 = 2;
  localparam int unsigned BIT_CLK_EN = 3;
  // direct_xfer_ctrl fields
  localparam int unsigned POS_READ_LAT = 0;
  localparam int unsigned POS_WRITE_LAT = 4;
  localparam logic [31:0] RESET_GLOBAL_CTRL = 32'h0000_0008;
  localparam logic [31:0] RESET_XFER_CTRL = 32'h0000_0000;
  // interface clock periods, counted in iface_in_clk rising edges
  localparam int unsigned FLOAT_MIN_E = 2;
  localparam int unsigned RESUME_MIN_E = 2;
  localparam int unsigned RESUME_MAX_E = 7;
  localparam int unsigned ACK_MAX_E = 2;
  localparam int unsigned BOOT_W = 7;
  // sdram command codes {a10, cs_n, row, col, we}
  // a10 alone tells precharge-all from single-bank deactivate
  typedef enum logic [4:0] {
    cmd_nop = 5'h07,
    cmd_activate = 5'h03,
    cmd_precharge_all = 5'h12,
    cmd_deactivate = 5'h02,
    cmd_refresh = 5'h01,
    cmd_mode_set = 5'h00,
    cmd_read = 5'h05,
    cmd_write = 5'h04
  } sd_cmd_type;
  typedef enum logic [2:0] {
    hs_idle = 3'h0,
    hs_drain = 3'h1,
    hs_float = 3'h2,
    hs_held = 3'h3,
    hs_resume = 3'h4,
    hs_release = 3'h5
  } hold_state_type;
endpackage

// >>> src/sync_edge.sv
`timescale 1ns/1ps
// two-flop synchroniser with rising edge detect on the second stage
module sync_edge
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic din, // asynchronous input
  output logic dout, // synchronised level
  output logic rise // one-cycle pulse on rising edge
);
  logic meta;
  logic last;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= 1'b0;
      dout <= 1'b0;
      last <= 1'b0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
      last <= dout;
    end
  end
  assign rise = dout & ~last;
endmodule

// >>> src/sdram_pdt_bus_hold_ctrl.sv
`timescale 1ns/1ps
// sdram strobe driver, direct-transfer strobe and bus hold controller
// Function
// - shared strobes act as column strobe, write enable, row strobe
// - direct strobe only for dma transfers with direct bit set
// - direct read does not capture the data bus
// - read direct strobe delayed 0..3 cycles by read latency field
// - direct write leaves data bus undriven
// - write direct strobe delayed 0..3 cycles by write latency field
// - pending transfers finish before hold is acknowledged
// - hold disable bit postpones hold grant indefinitely
// - bus floats no sooner than two periods after hold request
// - hold acknowledge falls zero to two periods after float
// - bus driven again two to seven periods after request rises
// - acknowledge rises zero to two periods after bus resumes
// - output clock floats in hold only when its float bit set
// - output clock float and resume timed like the bus
// - floated bus covers selects, enables, data, address, strobes
// - bus request, clock enable, direct strobe change on clock rise
// - boot configuration captured at reset release
module sdram_pdt_bus_hold_ctrl
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic iface_in_clk, // interface clock from pin
  input wire logic hold_req_n, // hold request pin, active low
  input wire logic [6:0] boot_cfg, // boot configuration pins
  input wire logic xfer_req, // transfer request, internal
  input wire logic xfer_write, // 1 write, 0 read
  input wire logic direct_read_sel, // dma channel direct read bit
  input wire logic direct_write_sel, // dma channel direct write bit
  input wire logic [3:0] xfer_cs, // chip select of transfer
  input wire logic [3:0] xfer_be, // byte enables of transfer
  input wire logic [19:0] xfer_addr, // address of transfer
  input wire logic [31:0] xfer_wdata, // write data
  output logic xfer_busy, // transfer in progress
  output logic xfer_done, // one-cycle pulse at end
  output logic [31:0] xfer_rdata, // captured read data
  output logic bus_request_out, // bus request pin
  output logic bus_hold_ack_n, // hold acknowledge, active low
  output logic iface_out_clk1, // output clock 1
  output logic iface_out_clk1_oe, // output clock 1 drive
  output logic iface_out_clk2, // output clock 2
  output logic iface_out_clk2_oe, // output clock 2 drive
  output logic [3:0] chip_sel_n, // chip selects
  output logic [3:0] byte_en_n, // byte enables
  output logic [19:0] ext_addr, // address lines 22..3
  output logic [31:0] ext_data_o, // data out
  output logic ext_data_oe, // data drive
  input wire logic [31:0] ext_data_i, // data in
  output logic sdram_row_strobe, // row strobe, active low
  output logic sdram_col_strobe, // column strobe, active low
  output logic sdram_write_en, // write enable, active low
  output logic sdram_clk_en, // sdram clock enable
  output logic secondary_out_en, // secondary output enable
  output logic direct_xfer_strobe, // direct transfer strobe, active low
  output logic bus_oe // control group drive enable
);
  logic eclk;
  logic erise;
  logic hold_n;
  logic [31:0] iface_global_ctrl;
  logic [31:0] direct_xfer_ctrl;
  logic [6:0] boot_latch;
  logic [6:0] boot_meta;
  logic [6:0] boot_sync;
  logic boot_done;
  ext_bus_pkg::sd_cmd_type sw_cmd;
  logic sw_cmd_pend;
  ext_bus_pkg::hold_state_type hstate;
  logic [2:0] hcnt;
  logic bus_float;
  logic [1:0] xphase;
  logic xdirect;
  logic xwr;
  logic [3:0] pdt_pipe;
  logic [1:0] lat;
  logic pdt_next;
  logic apb_wr;

  sync_edge u_clk_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .din(iface_in_clk),
    .dout(eclk),
    .rise(erise)
  );
  sync_edge u_hold_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .din(hold_req_n),
    .dout(hold_n),
    .rise()
  );

  assign pready = 1'b1;
  assign apb_wr = psel & penable & pwrite;
  assign pslverr = psel & penable & (paddr > ext_bus_pkg::OFF_BOOT);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      iface_global_ctrl <= ext_bus_pkg::RESET_GLOBAL_CTRL;
      direct_xfer_ctrl <= ext_bus_pkg::RESET_XFER_CTRL;
    end
    else if (apb_wr && paddr == ext_bus_pkg::OFF_GLOBAL_CTRL)
      iface_global_ctrl <= {28'h0000000, pwdata[3:0]};
    else if (apb_wr && paddr == ext_bus_pkg::OFF_XFER_CTRL)
      direct_xfer_ctrl <= {26'h0000000, pwdata[5:4], 2'h0, pwdata[1:0]};
  end

  // software command issue; latched at any time, driven only while the bus is idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_cmd <= ext_bus_pkg::cmd_nop;
      sw_cmd_pend <= 1'b0;
    end
    else if (apb_wr && paddr == ext_bus_pkg::OFF_CMD)
    begin
      sw_cmd_pend <= 1'b1;
      case (pwdata[2:0])
        3'h0: sw_cmd <= ext_bus_pkg::cmd_activate;
        3'h1: sw_cmd <= ext_bus_pkg::cmd_precharge_all;
        3'h2: sw_cmd <= ext_bus_pkg::cmd_deactivate;
        3'h3: sw_cmd <= ext_bus_pkg::cmd_refresh;
        3'h4: sw_cmd <= ext_bus_pkg::cmd_mode_set;
        default: sw_cmd <= ext_bus_pkg::cmd_refresh; // self-refresh entry
      endcase
    end
    else if (erise && xphase == 2'd0 && !bus_float)
      sw_cmd_pend <= 1'b0;
  end

  // no reset here, so the pin synchroniser is already full at release
  always_ff @(posedge pclk)
  begin
    boot_meta <= boot_cfg;
    boot_sync <= boot_meta;
  end

  // boot pins are sampled on the first clock after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_latch <= 7'h00;
      boot_done <= 1'b0;
    end
    else if (!boot_done)
    begin
      boot_latch <= boot_sync;
      boot_done <= 1'b1;
    end
  end

  always_comb
  begin
    prdata = 32'h00000000;
    if (psel && !pwrite)
    begin
      case (paddr)
        ext_bus_pkg::OFF_GLOBAL_CTRL: prdata = iface_global_ctrl;
        ext_bus_pkg::OFF_XFER_CTRL: prdata = direct_xfer_ctrl;
        ext_bus_pkg::OFF_STATUS:
          prdata = {27'h0, sw_cmd_pend, xfer_busy, bus_float,
                    hstate == ext_bus_pkg::hs_held, !hold_n};
        ext_bus_pkg::OFF_BOOT: prdata = {25'h0, boot_latch};
        default: prdata = 32'h00000000;
      endcase
    end
  end

  // transfer sequencer: phase 1 row open, 2 column command, 3 data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xphase <= 2'd0;
      xdirect <= 1'b0;
      xwr <= 1'b0;
      xfer_rdata <= 32'h00000000;
      xfer_done <= 1'b0;
    end
    else
    begin
      xfer_done <= 1'b0;
      if (erise)
      begin
        case (xphase)
          2'd0:
            // no new transfer once a hold is pending
            if (xfer_req && hstate == ext_bus_pkg::hs_idle && hold_n
                && !sw_cmd_pend)
            begin
              xphase <= 2'd1;
              xwr <= xfer_write;
              xdirect <= xfer_write ? direct_write_sel
                                    : direct_read_sel;
            end
          2'd1: xphase <= 2'd2;
          2'd2: xphase <= 2'd3;
          default:
          begin
            xphase <= 2'd0;
            xfer_done <= 1'b1;
            if (!xwr && !xdirect)
              xfer_rdata <= ext_data_i;
          end
        endcase
      end
    end
  end
  assign xfer_busy = xphase != 2'd0;

  // hold handshake, counted in interface clock rises
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hstate <= ext_bus_pkg::hs_idle;
      hcnt <= 3'd0;
      bus_float <= 1'b0;
      bus_hold_ack_n <= 1'b1;
    end
    else if (erise)
    begin
      case (hstate)
        ext_bus_pkg::hs_idle:
          if (!hold_n && !iface_global_ctrl[ext_bus_pkg::BIT_HOLD_DISABLE])
          begin
            hstate <= ext_bus_pkg::hs_drain;
            hcnt <= 3'd1;
          end
        ext_bus_pkg::hs_drain:
        begin
          if (hcnt != 3'd7)
            hcnt <= hcnt + 3'd1;
          if (!xfer_busy && hcnt >= 3'(ext_bus_pkg::FLOAT_MIN_E))
          begin
            bus_float <= 1'b1;
            hstate <= ext_bus_pkg::hs_float;
          end
        end
        ext_bus_pkg::hs_float:
        begin
          bus_hold_ack_n <= 1'b0;
          hstate <= ext_bus_pkg::hs_held;
        end
        ext_bus_pkg::hs_held:
          if (hold_n)
          begin
            hstate <= ext_bus_pkg::hs_resume;
            hcnt <= 3'd1;
          end
        ext_bus_pkg::hs_resume:
        begin
          hcnt <= hcnt + 3'd1;
          if (hcnt >= 3'(ext_bus_pkg::RESUME_MIN_E))
          begin
            bus_float <= 1'b0;
            hstate <= ext_bus_pkg::hs_release;
          end
        end
        ext_bus_pkg::hs_release:
        begin
          bus_hold_ack_n <= 1'b1;
          hstate <= ext_bus_pkg::hs_idle;
        end
        default: hstate <= ext_bus_pkg::hs_idle;
      endcase
    end
  end

  // direct strobe delay line, one stage per interface clock
  assign lat = xwr ? direct_xfer_ctrl[5:4] : direct_xfer_ctrl[1:0];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pdt_pipe <= 4'h0;
    else if (erise)
      pdt_pipe <= {pdt_pipe[2:0], xdirect && xphase == 2'd3};
  end
  assign pdt_next = pdt_pipe[lat];

  // pin outputs all change on the interface clock rise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {chip_sel_n, sdram_row_strobe, sdram_col_strobe, sdram_write_en}
        <= {4'hf, 3'h7};
      byte_en_n <= 4'hf;
      ext_addr <= 20'h00000;
      ext_data_o <= 32'h00000000;
      ext_data_oe <= 1'b0;
      sdram_clk_en <= 1'b0;
      direct_xfer_strobe <= 1'b1;
      bus_request_out <= 1'b0;
      secondary_out_en <= 1'b1;
    end
    else if (erise)
    begin
      sdram_clk_en <= iface_global_ctrl[ext_bus_pkg::BIT_CLK_EN];
      direct_xfer_strobe <= ~pdt_next;
      bus_request_out <= xfer_req | sw_cmd_pend;
      secondary_out_en <= 1'b1;
      byte_en_n <= (xphase == 2'd2) ? ~xfer_be : 4'hf;
      ext_addr <= xfer_addr;
      ext_data_o <= xfer_wdata;
      ext_data_oe <= xphase == 2'd2 && xwr && !xdirect;
      {chip_sel_n, sdram_row_strobe, sdram_col_strobe, sdram_write_en}
        <= {4'hf, 3'h7};
      if (xphase == 2'd1)
        {chip_sel_n, sdram_row_strobe, sdram_col_strobe, sdram_write_en}
          <= {~xfer_cs, ext_bus_pkg::cmd_activate[2:0]};
      else if (xphase == 2'd2)
        {chip_sel_n, sdram_row_strobe, sdram_col_strobe, sdram_write_en}
          <= {~xfer_cs, xwr ? ext_bus_pkg::cmd_write[2:0]
                            : ext_bus_pkg::cmd_read[2:0]};
      else if (sw_cmd_pend && xphase == 2'd0 && !bus_float)
        {chip_sel_n, sdram_row_strobe, sdram_col_strobe, sdram_write_en}
          <= {4'h0, sw_cmd[2:0]};
    end
  end

  assign bus_oe = ~bus_float;
  assign iface_out_clk1 = eclk;
  assign iface_out_clk2 = eclk;
  assign iface_out_clk1_oe =
    ~(bus_float & iface_global_ctrl[ext_bus_pkg::BIT_FLOAT_SEL1]);
  assign iface_out_clk2_oe =
    ~(bus_float & iface_global_ctrl[ext_bus_pkg::BIT_FLOAT_SEL2]);
endmodule

// >>> testbench/ext_bus_checker.sv
// concurrent checks on the hold handshake and data drive pins
`timescale 1ns/1ps
module ext_bus_checker
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic hold_req_n, // hold request pin
  input wire logic bus_hold_ack_n, // hold acknowledge
  input wire logic bus_oe, // control group drive
  input wire logic ext_data_oe, // data drive
  input wire logic iface_out_clk1_oe, // clock 1 drive
  input wire logic iface_out_clk2_oe, // clock 2 drive
  input wire logic xfer_busy, // transfer in progress
  input wire logic xfer_write, // transfer direction
  input wire logic direct_write_sel // direct write bit
);
  // 2E is 16 pclk at the bench rates; counters saturate
  logic [5:0] low_cnt;
  logic [5:0] high_cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_cnt <= 6'h0;
      high_cnt <= 6'h0;
    end
    else
    begin
      low_cnt <= hold_req_n ? 6'h0 : low_cnt + {5'h0, low_cnt != 6'h3f};
      high_cnt <= !hold_req_n ? 6'h0 : high_cnt + {5'h0, high_cnt != 6'h3f};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_float_not_early: assert property ($fell(bus_oe) |-> low_cnt >= 6'h10)
    else $error("bus floated too soon after hold request");
  a_ack_after_float: assert property ($fell(bus_hold_ack_n) |-> !bus_oe)
    else $error("hold acknowledged before bus floated");
  a_ack_follows_float: assert property ($fell(bus_oe) |-> ##[0:16] !bus_hold_ack_n)
    else $error("hold acknowledge late after float");
  a_resume_not_early: assert property ($rose(bus_oe) |-> high_cnt >= 6'h10)
    else $error("bus driven too soon after hold release");
  a_resume_bound: assert property ($rose(hold_req_n) && !bus_oe |-> ##[1:56] bus_oe)
    else $error("bus not driven again in time");
  a_ack_release: assert property ($rose(bus_oe) |-> ##[0:16] bus_hold_ack_n)
    else $error("hold acknowledge late after resume");
  a_clk_float_min: assert property ($fell(iface_out_clk1_oe) |-> low_cnt >= 6'h10)
    else $error("output clock floated too soon");
  a_clk_resume_min: assert property ($rose(iface_out_clk1_oe) |-> high_cnt >= 6'h10)
    else $error("output clock driven too soon");
  a_idle_before_ack: assert property ($fell(bus_hold_ack_n) |-> !xfer_busy)
    else $error("hold acknowledged during a transfer");
  a_data_float_hold: assert property (!bus_oe |-> !ext_data_oe)
    else $error("data driven while bus is held");
  a_direct_write_z: assert property (ext_data_oe && xfer_busy |-> xfer_write && !direct_write_sel)
    else $error("data driven on a direct or read transfer");
endmodule
bind sdram_pdt_bus_hold_ctrl ext_bus_checker ext_bus_checker_inst (.*);

// >>> testbench/far_side.sv
// sdram data return and a bus-hold master on the far side
`timescale 1ns/1ps
module far_side
#(
  parameter logic [31:0] READ_WORD = 32'h3c5a_96e1 // returned on the first read
)
(
  input wire logic pclk, // system clock
  input wire logic want_hold, // bench asks for the bus
  input wire logic bus_hold_ack_n, // grant from device
  input wire logic [3:0] chip_sel_n, // selects
  input wire logic sdram_row_strobe, // row strobe
  input wire logic sdram_col_strobe, // column strobe
  input wire logic sdram_write_en, // write enable
  output logic hold_req_n, // hold request
  output logic [31:0] ext_data_i // data to device
);
  logic [4:0] rd_cnt = 5'h0;
  // each read window returns a fresh word so a stray capture shows
  logic [31:0] rd_word = READ_WORD;
  logic [3:0] ack_cnt = 4'h0;
  initial hold_req_n = 1'b1;
  initial ext_data_i = 32'h0;
  always @(posedge pclk)
  begin
    // data stays a few periods after a read, then wanders
    if (chip_sel_n != 4'hf && sdram_row_strobe && !sdram_col_strobe && sdram_write_en)
      rd_cnt <= 5'h1f;
    else if (rd_cnt != 5'h0)
    begin
      rd_cnt <= rd_cnt - 5'h1;
      if (rd_cnt == 5'h1)
        rd_word <= rd_word + 32'h1;
    end
    ext_data_i <= (rd_cnt != 5'h0) ? rd_word : ~ext_data_i;
    ack_cnt <= bus_hold_ack_n ? 4'h0 : ack_cnt + {3'h0, ack_cnt != 4'hf};
    if (want_hold)
      hold_req_n <= 1'b0;
    else if (bus_hold_ack_n || ack_cnt > 4'h9)
      hold_req_n <= 1'b1;
  end
endmodule

// >>> testbench/test_sdram_pdt_bus_hold_ctrl.sv
// self-checking bench for the sdram, direct-transfer and bus-hold block
`timescale 1ns/1ps
module test_sdram_pdt_bus_hold_ctrl;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, iface_in_clk;
  logic hold_req_n, xfer_req, xfer_write, direct_read_sel, direct_write_sel;
  logic xfer_busy, xfer_done, bus_request_out, bus_hold_ack_n, want_hold;
  logic iface_out_clk1, iface_out_clk1_oe, iface_out_clk2, iface_out_clk2_oe;
  logic ext_data_oe, sdram_row_strobe, sdram_col_strobe, sdram_write_en;
  logic sdram_clk_en, secondary_out_en, direct_xfer_strobe, bus_oe, oe_seen;
  logic [7:0] paddr;
  logic [6:0] boot_cfg;
  logic [3:0] xfer_cs, xfer_be, chip_sel_n, byte_en_n, be_seen;
  logic [19:0] xfer_addr, ext_addr, ad_seen;
  logic req_seen;
  logic [31:0] pwdata, prdata, xfer_wdata, xfer_rdata, ext_data_o, ext_data_i;
  logic [31:0] rd, wd, wd_seen, r0, seed;
  logic [2:0] seen_cmd;
  int failures, comparisons, cycles, t_act, t_pdt, lows, base_r, base_w, k, n;
  sdram_pdt_bus_hold_ctrl sdram_pdt_bus_hold_ctrl_inst (.*);
  far_side far_side_inst (.*);
  always #4 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      failures++;
      wrap_up();
    end
  end
  function automatic int lat_exp(input int base, input int l);
    return base + 8 * l; // one interface period per latency step
  endfunction
  function automatic logic [2:0] cmd_exp(input int c);
    case (c)
      0: return 3'b011;
      1, 2: return 3'b010;
      4: return 3'b000;
      default: return 3'b001;
    endcase
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    r0 = 32'(pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_ack(input logic v);
    for (n = 0; n < 400 && bus_hold_ack_n !== v; n++)
      @(posedge pclk);
    check("hold acknowledge", 32'(bus_hold_ack_n), 32'(v));
  endtask
  task automatic xfer(input logic w, input logic dr, input logic dw);
    int j, done_at;
    rd = $random(seed);
    wd = $random(seed);
    xfer_req <= 1'b1;
    xfer_write <= w;
    direct_read_sel <= dr;
    direct_write_sel <= dw;
    xfer_addr <= rd[19:0];
    xfer_wdata <= wd;
    {t_act, t_pdt, lows, oe_seen, done_at} = {-32'sd1, -32'sd1, 32'h0, 1'b0, -32'sd1};
    {req_seen, be_seen, ad_seen} = {1'b0, 4'hf, 20'h0};
    for (j = 0; j < 400 && (done_at < 0 || j < done_at + 40); j++)
    begin
      @(posedge pclk);
      if (xfer_done === 1'b1 && done_at < 0)
      begin
        done_at = j;
        xfer_req <= 1'b0;
      end
      if (t_act < 0 && sdram_row_strobe === 1'b0)
        t_act = j;
      if (direct_xfer_strobe === 1'b0)
        lows++;
      if (direct_xfer_strobe === 1'b0 && t_pdt < 0)
        t_pdt = j;
      if (ext_data_oe === 1'b1)
        {oe_seen, wd_seen} = {1'b1, ext_data_o};
      if (byte_en_n !== 4'hf)
        {be_seen, ad_seen} = {byte_en_n, ext_addr};
      if (bus_request_out === 1'b1)
        req_seen = 1'b1;
    end
    check("transfer done", 32'(done_at >= 0), 32'h1);
    check("bus request", 32'(req_seen), 32'h1);
    check("bus request idle", 32'(bus_request_out), 32'h0);
  endtask
  task automatic wrap_up;
    if (failures == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, xfer_req, want_hold} = 7'h0;
    {xfer_write, direct_read_sel, direct_write_sel, failures, comparisons} = 0;
    {paddr, pwdata, xfer_wdata, xfer_addr, xfer_cs, xfer_be, cycles} = 0;
    seed = 32'hdf89f4dd;
    rd = $random(seed);
    boot_cfg = rd[6:0];
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    xfer_cs <= 4'h1;
    xfer_be <= 4'hf;
    @(posedge pclk);
    apb(1'b0, ext_bus_pkg::OFF_GLOBAL_CTRL, 32'h0);
    check("global reset", rd, ext_bus_pkg::RESET_GLOBAL_CTRL);
    apb(1'b0, ext_bus_pkg::OFF_XFER_CTRL, 32'h0);
    check("latency reset", rd, ext_bus_pkg::RESET_XFER_CTRL);
    apb(1'b0, ext_bus_pkg::OFF_BOOT, 32'h0);
    check("boot capture", rd, {25'h0, boot_cfg});
    check("secondary enable", 32'(secondary_out_en), 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped error", r0, 32'h1);
    xfer(1'b0, 1'b0, 1'b0);
    check("read data", xfer_rdata, far_side_inst.READ_WORD);
    check("address", 32'(ad_seen), 32'(rd[19:0]));
    check("byte enables", 32'(be_seen), {28'h0, ~xfer_be});
    check("plain read strobe", lows, 0);
    xfer(1'b1, 1'b0, 1'b0);
    check("write data", wd_seen, wd);
    check("plain write strobe", lows, 0);
    for (k = 0; k < 4; k++)
    begin
      apb(1'b1, ext_bus_pkg::OFF_XFER_CTRL, 32'(k * 17));
      r0 = xfer_rdata;
      xfer(1'b0, 1'b1, 1'b0);
      check("direct read keeps data", xfer_rdata, r0);
      check("read strobe width", lows, 8);
      base_r = (k == 0) ? t_pdt - t_act : base_r;
      check("read latency", t_pdt - t_act, lat_exp(base_r, k));
      xfer(1'b1, 1'b0, 1'b1);
      check("direct write undriven", 32'(oe_seen), 32'h0);
      base_w = (k == 0) ? t_pdt - t_act : base_w;
      check("write latency", t_pdt - t_act, lat_exp(base_w, k));
    end
    apb(1'b1, ext_bus_pkg::OFF_GLOBAL_CTRL, 32'h0);
    repeat (40) @(posedge pclk);
    check("clock enable off", 32'(sdram_clk_en), 32'h0);
    apb(1'b1, ext_bus_pkg::OFF_GLOBAL_CTRL, 32'h8);
    repeat (40) @(posedge pclk);
    check("clock enable on", 32'(sdram_clk_en), 32'h1);
    for (k = 0; k < 6; k++)
    begin
      apb(1'b1, ext_bus_pkg::OFF_CMD, 32'(k));
      seen_cmd = 3'h7;
      for (n = 0; n < 80 && seen_cmd == 3'h7; n++)
      begin
        @(posedge pclk);
        if (chip_sel_n != 4'hf)
          seen_cmd = {sdram_row_strobe, sdram_col_strobe, sdram_write_en};
      end
      check("sdram command", 32'(seen_cmd), 32'(cmd_exp(k)));
      repeat (40) @(posedge pclk);
    end
    apb(1'b1, ext_bus_pkg::OFF_GLOBAL_CTRL, 32'hb);
    want_hold <= 1'b1;
    repeat (300) @(posedge pclk);
    check("hold postponed", 32'(bus_hold_ack_n), 32'h1);
    apb(1'b1, ext_bus_pkg::OFF_GLOBAL_CTRL, 32'ha);
    wait_ack(1'b0);
    // 40 pclk span five interface periods, so ten level changes
    {n, k, r0[1:0]} = {32'h0, 32'h0, iface_out_clk1, iface_out_clk2};
    repeat (40)
    begin
      @(posedge pclk);
      n += int'(iface_out_clk2 !== r0[0]);
      k += int'(iface_out_clk1 !== r0[1]);
      r0[1:0] = {iface_out_clk1, iface_out_clk2};
    end
    check("clock 2 toggles", n, 10);
    check("clock 1 toggles", k, 10);
    check("clock 1 floated", 32'(iface_out_clk1_oe), 32'h0);
    check("clock 2 driven", 32'(iface_out_clk2_oe), 32'h1);
    want_hold <= 1'b0;
    wait_ack(1'b1);
    check("clock 1 back", 32'(iface_out_clk1_oe), 32'h1);
    fork
      xfer(1'b1, 1'b0, 1'b0);
      begin
        repeat (12) @(posedge pclk);
        want_hold <= 1'b1;
      end
    join
    wait_ack(1'b0);
    check("idle in hold", 32'(xfer_busy), 32'h0);
    want_hold <= 1'b0;
    wait_ack(1'b1);
    wrap_up();
  end
  initial
  begin
    iface_in_clk = 1'b0;
    #3;
    forever #32 iface_in_clk = ~iface_in_clk;
  end
endmodule
